// ===== logic/epf_outputs.sv
// Pulse, fault and reverse-power outputs of the energy metering path.
// Assumes power and current magnitudes arrive from logic on mclk; selects are pins.
//
// Functional notes
// - Alarm high when currents differ over 6.25%
// - Alarm clears once mismatch disappears
// - Reverse flag high on negative active power
// - Reverse flag clears on positive power, unlatched
// - Reverse flag changes only with calibration pulse
// - Calibration pulses follow instantaneous active power
// - Calibration select scales calibration frequency
// - Two rate selects pick four scalings
// - Low-rate outputs follow average power, strong drive
// - Low-rate pulses 120 ms, shorter when fast
// - Calibration pulses 90 ms, shorter when fast
// - Output b falls half period after a
// - Low-rate pulses spaced quarter sampling period
`timescale 1ns/10ps

module epf_outputs #(
	parameter int CAL_WIDTH_CYC = epf_pkg::CAL_WIDTH_CYC,   // Calibration width, cycles
	parameter int F_WIDTH_CYC  = epf_pkg::F_WIDTH_CYC       // Low-rate width, cycles
) (
	input  wire logic                      mclk,                    // Core clock
	input  wire logic                      nrst,                    // Asynchronous reset, low
	input  wire logic                      ce,                      // Clock enable
	input  wire logic [epf_pkg::PWR_W-1:0] power_sample,            // Signed active power
	input  wire logic                      power_valid,             // Power sample strobe
	input  wire logic [epf_pkg::PWR_W-1:0] current_input_a,         // Channel a magnitude
	input  wire logic [epf_pkg::PWR_W-1:0] current_input_b,         // Channel b magnitude
	input  wire logic                      calibration_rate_select, // Pin, calibration scaling
	input  wire logic                      rate_select_high,        // Pin, rate code msb
	input  wire logic                      rate_select_low,         // Pin, rate code lsb
	output logic                           calibration_pulse_out,   // Instantaneous power pulses
	output logic                           low_rate_pulse_a,        // Average power pulses
	output logic                           low_rate_pulse_b,        // Alternate average pulses
	output logic                           miswire_alarm,           // Current mismatch
	output logic                           reverse_power_flag       // Negative power seen
);
	import epf_pkg::*;

	// ==========================================================
	// Reset release
	logic rst_meta_n;                                      // First reset stage
	logic rst_n;                                           // Synchronised reset

	// Release through two flops, assert at once
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	// ==========================================================
	// State
	typedef struct packed {
		logic [SEL_W-1:0] sel_st1;                     // Select sync stage 1
		logic [SEL_W-1:0] sel_st2;                     // Select sync stage 2
		logic [SEL_W-1:0] sel_st3;                     // Select sync stage 3
		logic [SEL_W-1:0] sel;                         // Accepted select levels
		logic [PWR_W-1:0] avg;                         // Averaged power, signed
		logic             fault;                       // Alarm output
		logic             rev;                         // Reverse flag output
		logic             cal_o;                       // Calibration output
		logic             fa;                          // Low-rate output a
		logic             fb;                          // Low-rate output b
		epf_phase_t       phase;                       // Output for next pulse
		epf_phase_t       cur;                         // Output owning this pulse
		logic [GAP_W-1:0] gap;                         // Spacing countdown
	} epf_top_st_t;

	epf_top_st_t s_q;                                      // Registered state
	epf_top_st_t s_d;                                      // Next state

	logic [PWR_W-1:0]   big;                               // Larger current
	logic [PWR_W-1:0]   lesser;                            // Smaller current
	logic [PWR_W-1:0]   diff;                              // Current difference
	logic               mism;                              // Mismatch present
	logic [PWR_W:0]     delta;                             // Filter step
	logic [PWR_W-1:0]   cal_shift;                         // Calibration gain shift
	epf_phase_t         cur_now;                           // Owner seen this cycle

	epf_pulse_if cal_if ();                                // Calibration generator link
	epf_pulse_if f_if   ();                                // Low-rate generator link

	// ==========================================================
	// Mismatch test: difference times sixteen above the larger
	always_comb begin
		big    = (current_input_a >= current_input_b) ? current_input_a : current_input_b;
		lesser = (current_input_a >= current_input_b) ? current_input_b : current_input_a;
		diff   = big - lesser;
		mism   = {diff, 4'h0} > {4'h0, big};
	end

	// ==========================================================
	// Generator feeds
	// Calibration threshold is the low-rate one shifted down 4 or 6 bits, per calibration select
	assign cal_shift    = s_q.sel[SEL_CAL] ? PWR_W'(CAL_SHIFT_HIGH) : PWR_W'(CAL_SHIFT_LOW);
	assign cal_if.valid = power_valid;
	assign cal_if.mag   = epf_abs(power_sample);
	assign cal_if.thr   = epf_rate_thr(s_q.sel[SEL_HIGH:SEL_LOW]) >> cal_shift;
	assign cal_if.hold  = 1'b0;
	assign f_if.valid  = power_valid;
	assign f_if.mag    = epf_abs(s_q.avg);
	assign f_if.thr    = epf_rate_thr(s_q.sel[SEL_HIGH:SEL_LOW]);
	// No new low-rate pulse until the previous one is down and spaced
	assign f_if.hold   = f_if.pulse | (s_q.gap != '0);

	// ==========================================================
	// Next-state logic
	always_comb begin
		s_d = s_q;
		// Pin selects: three flops, accept a bit once stages two and three agree
		s_d.sel_st1 = {calibration_rate_select, rate_select_high, rate_select_low};
		s_d.sel_st2 = s_q.sel_st1;
		s_d.sel_st3 = s_q.sel_st2;
		// Agreeing stages win either way; while they differ the old level is kept
		s_d.sel     = (s_q.sel_st2 & s_q.sel_st3) | (s_q.sel & (s_q.sel_st2 ^ s_q.sel_st3));
		// Single-pole average; slow response is the price of a steady low rate
		delta = {s_q.avg[PWR_W-1], s_q.avg};
		if (power_valid) begin
			delta = {power_sample[PWR_W-1], power_sample} - {s_q.avg[PWR_W-1], s_q.avg};
			s_d.avg = s_q.avg + PWR_W'($signed(delta) >>> AVG_SHIFT);
		end
		// Alarm follows the mismatch level directly
		s_d.fault = mism;
		// Reverse flag sampled only when a calibration pulse starts
		if (cal_if.fire) begin
			s_d.rev = s_q.avg[PWR_W-1];
		end
		s_d.cal_o = cal_if.pulse;
		// Alternate low-rate pulses between the two outputs
		cur_now = f_if.fire ? s_q.phase : s_q.cur;
		if (f_if.fire) begin
			s_d.cur   = s_q.phase;
			s_d.phase = (s_q.phase == EPF_PH_A) ? EPF_PH_B : EPF_PH_A;
		end
		s_d.fa = f_if.pulse && (cur_now == EPF_PH_A);
		s_d.fb = f_if.pulse && (cur_now == EPF_PH_B);
		// Spacing counts from the falling edge of either output
		if (f_if.pulse) begin
			s_d.gap = GAP_W'(MIN_GAP_CYC);
		end else if (s_q.gap != '0) begin
			s_d.gap = s_q.gap - 8'h01;
		end
	end

	// State register; every output held low in reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{sel_st1: '0, sel_st2: '0, sel_st3: '0, sel: '0, avg: '0,
			         fault: 1'b0, rev: 1'b0, cal_o: 1'b0, fa: 1'b0, fb: 1'b0,
			         phase: EPF_PH_A, cur: EPF_PH_A, gap: '0};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Generators
	epf_pulse_gen #(.WIDTH_CYC(CAL_WIDTH_CYC)) u_cal_gen (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ce    (ce),
		.lnk   (cal_if)
	);

	epf_pulse_gen #(.WIDTH_CYC(F_WIDTH_CYC)) u_f_gen (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ce    (ce),
		.lnk   (f_if)
	);

	assign calibration_pulse_out = s_q.cal_o;
	assign low_rate_pulse_a      = s_q.fa;
	assign low_rate_pulse_b      = s_q.fb;
	assign miswire_alarm         = s_q.fault;
	assign reverse_power_flag    = s_q.rev;

	// ==========================================================
	// Checks
	fault_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && mism |=> miswire_alarm)
		else $error("alarm missed a mismatch");
	fault_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && !mism |=> !miswire_alarm)
		else $error("alarm stuck after mismatch ended");
	rev_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && cal_if.fire && s_q.avg[PWR_W-1] |=> reverse_power_flag && calibration_pulse_out)
		else $error("reverse flag not raised with pulse");
	rev_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && cal_if.fire && !s_q.avg[PWR_W-1] |=> !reverse_power_flag)
		else $error("reverse flag not cleared");
	rev_stable_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!(ce && cal_if.fire) |=> $stable(reverse_power_flag))
		else $error("reverse flag moved between pulses");
	f_alternate_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && f_if.fire && s_q.phase == EPF_PH_A |=> low_rate_pulse_a && !low_rate_pulse_b
		##0 s_q.phase == EPF_PH_B)
		else $error("low-rate outputs not alternating");
	f_spacing_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && $fell(f_if.pulse) |-> s_q.gap == GAP_W'(MIN_GAP_CYC))
		else $error("spacing countdown not started");
	f_exclusive_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!(low_rate_pulse_a && low_rate_pulse_b))
		else $error("both low-rate outputs high");
	reset_low_a: assert property (@(posedge mclk)
		!rst_n |-> !calibration_pulse_out && !low_rate_pulse_a && !low_rate_pulse_b &&
		!miswire_alarm && !reverse_power_flag)
		else $error("output high during reset");

	cal_pulse_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(calibration_pulse_out));
	f_b_pulse_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(low_rate_pulse_b));
	fault_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(miswire_alarm));
	rev_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(reverse_power_flag));

endmodule : epf_outputs

// ===== logic/epf_pkg.sv
// Constants, types and shared decode functions for the energy pulse and fault outputs.
// Assumes a single 100 MHz core clock and upstream power and current-magnitude samples.
package epf_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_HZ            = 100_000_000;        // Core clock rate
	localparam int F_WIDTH_MS        = 120;                // Low-rate pulse width
	localparam int CAL_WIDTH_MS      = 90;                 // Calibration pulse width
	localparam int F_WIDTH_CYC       = F_WIDTH_MS * (CLK_HZ / 1000);
	localparam int CAL_WIDTH_CYC     = CAL_WIDTH_MS * (CLK_HZ / 1000);
	localparam int SAMPLING_CLOCK_HZ = 450_000;            // Nominal sampling clock
	// Quarter sampling period, rounded up to whole core cycles
	localparam int MIN_GAP_CYC       = (CLK_HZ + 4 * SAMPLING_CLOCK_HZ - 1) / (4 * SAMPLING_CLOCK_HZ);

	// ==========================================================
	// Widths and arithmetic
	localparam int PWR_W          = 24;                    // Power and magnitude width
	localparam int ACC_W          = 32;                    // Frequency accumulator width
	localparam int GAP_W          = 8;                     // Gap counter width
	localparam int AVG_SHIFT      = 4;                     // Averaging filter weight
	localparam int MISMATCH_SHIFT = 4;                     // One sixteenth is 6.25 percent
	localparam int CAL_SHIFT_LOW  = 4;                     // Calibration gain, select low
	localparam int CAL_SHIFT_HIGH = 6;                     // Calibration gain, select high

	// ==========================================================
	// Select pin positions in the synchroniser vector
	localparam int SEL_LOW  = 0;                           // Rate select low
	localparam int SEL_HIGH = 1;                           // Rate select high
	localparam int SEL_CAL  = 2;                           // Calibration rate select
	localparam int SEL_W    = 3;                           // Number of select pins

	// ==========================================================
	// Frequency scaling thresholds, one per rate code
	localparam logic [ACC_W-1:0] F_THR0 = 32'h0800_0000;   // Slowest scaling
	localparam logic [ACC_W-1:0] F_THR1 = 32'h0400_0000;
	localparam logic [ACC_W-1:0] F_THR2 = 32'h0200_0000;
	localparam logic [ACC_W-1:0] F_THR3 = 32'h0100_0000;   // Fastest scaling

	// ==========================================================
	// Low-rate output phase
	typedef enum logic [1:0] {
		EPF_PH_A = 2'b01,                              // Next pulse on output a
		EPF_PH_B = 2'b10                               // Next pulse on output b
	} epf_phase_t;

	// Rate code to accumulator threshold
	function automatic logic [ACC_W-1:0] epf_rate_thr(input logic [1:0] code);
		unique case (code)
			2'h0: epf_rate_thr = F_THR0;
			2'h1: epf_rate_thr = F_THR1;
			2'h2: epf_rate_thr = F_THR2;
			2'h3: epf_rate_thr = F_THR3;
		endcase
	endfunction : epf_rate_thr

	// Two's complement magnitude; the most negative code still fits unsigned
	function automatic logic [PWR_W-1:0] epf_abs(input logic [PWR_W-1:0] v);
		epf_abs = v[PWR_W-1] ? (~v + 24'h000001) : v;
	endfunction : epf_abs

endpackage : epf_pkg

// ===== logic/epf_pulse_if.sv
// Carrier between the output top and one digital-to-frequency pulse generator.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps

// ==========================================================
// Pulse generator link
interface epf_pulse_if;
	logic                    valid;                    // Magnitude sample strobe
	logic [epf_pkg::PWR_W-1:0] mag;                    // Power magnitude
	logic [epf_pkg::ACC_W-1:0] thr;                    // Accumulator threshold
	logic                    hold;                     // Defers a new pulse
	logic                    pulse;                    // Shaped pulse level
	logic                    fire;                     // One-cycle pulse start

	modport gen  (input valid, mag, thr, hold, output pulse, fire);
	modport user (output valid, mag, thr, hold, input pulse, fire);
endinterface : epf_pulse_if

// ===== logic/epf_pulse_gen.sv
// Digital-to-frequency converter with pulse width shaping.
// Assumes a synchronised active-low reset and a clock enable from the top.
`timescale 1ns/10ps

module epf_pulse_gen #(
	parameter int WIDTH_CYC = epf_pkg::CAL_WIDTH_CYC        // Nominal pulse width in cycles
) (
	input  wire logic     mclk,                            // Core clock
	input  wire logic     rst_n,                           // Synchronised reset
	input  wire logic     ce,                              // Clock enable
	epf_pulse_if.gen      lnk                              // Sample in, pulse out
);
	import epf_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [ACC_W-1:0] acc;                         // Energy accumulator
		logic [31:0]      wcnt;                        // Cycles high so far
		logic [31:0]      pcnt;                        // Cycles since last start
		logic [31:0]      lastp;                       // Last measured period
		logic             pulse;                       // Output level
		logic             fire;                        // Start strobe
	} epf_gen_st_t;

	epf_gen_st_t s_q;                                      // Registered state
	epf_gen_st_t s_d;                                      // Next state
	logic [ACC_W:0] sum;                                   // Accumulator plus sample

	// Accumulate, fire on threshold, shape the width
	always_comb begin
		s_d      = s_q;
		s_d.fire = 1'b0;
		sum      = {1'b0, s_q.acc} + (lnk.valid ? {9'h000, lnk.mag} : 33'h000000000);
		if (s_q.pcnt != 32'hffff_ffff) begin
			s_d.pcnt = s_q.pcnt + 32'h0000_0001;
		end
		if (!lnk.hold && sum >= {1'b0, lnk.thr}) begin
			// Remainder kept so no energy is lost between pulses
			s_d.acc   = ACC_W'(sum - {1'b0, lnk.thr});
			s_d.fire  = 1'b1;
			s_d.pulse = 1'b1;
			s_d.wcnt  = 32'h0000_0000;
			s_d.lastp = s_q.pcnt;
			s_d.pcnt  = 32'h0000_0000;
		end else begin
			// Saturate while held; a stalled pulse is then only late
			s_d.acc = sum[ACC_W] ? {ACC_W{1'b1}} : sum[ACC_W-1:0];
			if (s_q.pulse) begin
				// Fixed width, cut to half the period when pulses come fast
				if (s_q.wcnt + 32'h0000_0001 >= 32'(WIDTH_CYC) ||
				    s_q.wcnt + 32'h0000_0001 >= {1'b0, s_q.lastp[31:1]}) begin
					s_d.pulse = 1'b0;
				end else begin
					s_d.wcnt = s_q.wcnt + 32'h0000_0001;
				end
			end
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{acc: '0, wcnt: '0, pcnt: '0, lastp: '1, pulse: 1'b0, fire: 1'b0};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign lnk.pulse = s_q.pulse;
	assign lnk.fire  = s_q.fire;

	// ==========================================================
	// Checks
	pulse_width_a: assert property (@(posedge mclk) disable iff (!rst_n)
		s_q.pulse |-> s_q.wcnt < 32'(WIDTH_CYC))
		else $error("pulse held beyond nominal width");
	fire_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
		s_q.fire |-> s_q.pulse && s_q.wcnt == 32'h0000_0000)
		else $error("pulse start without output high");
	hold_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && lnk.hold |=> !s_q.fire)
		else $error("pulse started while held");

endmodule : epf_pulse_gen

// ===== testbench/epf_counter_model.sv
// Pulse counter model standing in for the meter counter or stepper drive.
// Assumes it samples the design outputs on the same core clock.
`timescale 1ns/10ps

// ==========================================================
// Counter model
module epf_counter_model (
	input  wire logic mclk,    // Core clock
	input  wire logic cal,     // Calibration pulse line
	input  wire logic pa,      // Low-rate line a
	input  wire logic pb,      // Low-rate line b
	input  wire logic rev,     // Reverse power line
	output int        cal_n,   // Calibration pulses counted
	output int        cal_per, // Last calibration period, cycles
	output int        cal_wid, // Last calibration width, cycles
	output int        lr_wid,  // Last low-rate width, cycles
	output int        alt_err, // Low-rate pulses out of turn
	output int        gap_min, // Shortest low gap between low-rate pulses
	output int        fall_d0, // Older fall to fall interval
	output int        fall_d1, // Newer fall to fall interval
	output int        rev_err  // Flag moves without a calibration rise
);
	int   t, t_cr, t_lr, t_lf;          // Cycle count and edge times
	logic cal_q, pa_q, pb_q, rev_q;     // Previous samples
	logic next_b;                       // Which line should pulse next

	initial begin
		{t, t_cr, t_lr, t_lf, cal_n, cal_per, cal_wid, lr_wid} = '0;
		{alt_err, fall_d0, fall_d1, rev_err} = '0;
		gap_min = 1000000;
		{cal_q, pa_q, pb_q, rev_q, next_b} = '0;
	end

	// Edge bookkeeping; a real counter only sees edges, so do we
	always @(posedge mclk) begin
		t++;
		if (cal && !cal_q) begin
			cal_per = t - t_cr;
			t_cr = t;
			cal_n++;
		end
		if (!cal && cal_q)
			cal_wid = t - t_cr;
		// Flag may only move with a calibration rise
		if (rev !== rev_q && !(cal && !cal_q))
			rev_err++;
		if ((pa && !pa_q) || (pb && !pb_q)) begin
			if (t_lf > 0 && t - t_lf < gap_min)
				gap_min = t - t_lf;
			t_lr = t;
		end
		// Lines must take turns, a first
		if (pa && !pa_q) begin
			if (next_b) alt_err++;
			next_b = 1'b1;
		end
		if (pb && !pb_q) begin
			if (!next_b) alt_err++;
			next_b = 1'b0;
		end
		if ((!pa && pa_q) || (!pb && pb_q)) begin
			lr_wid = t - t_lr;
			fall_d0 = fall_d1;
			fall_d1 = t - t_lf;
			t_lf = t;
		end
		{cal_q, pa_q, pb_q, rev_q} = {cal, pa, pb, rev};
	end
endmodule : epf_counter_model

// ===== testbench/epf_outputs_test.sv
// Self-checking bench for the pulse, fault and reverse-power outputs.
// Assumes shortened pulse widths; the counter model measures the lines.
`timescale 1ns/10ps

// ==========================================================
// Bench top
module epf_outputs_test;
	import epf_pkg::*;
	logic             mclk, nrst, ce, pvalid, csel, shi, slo; // Drive
	logic [PWR_W-1:0] power, cur_a, cur_b;                    // Samples
	logic             cal, pa, pb, alarm, rev;                // Outputs
	int               cal_n, cal_per, cal_wid, lr_wid, alt_err, gap_min;
	int               fall_d0, fall_d1, rev_err, failures, n_compared, cyc, s;
	int               per_exp[4] = '{512, 256, 128, 64};     // 0x200000 >> code / 4096

	epf_outputs #(.CAL_WIDTH_CYC(20), .F_WIDTH_CYC(30)) uut (.mclk(mclk), .nrst(nrst), .ce(ce),
		.power_sample(power), .power_valid(pvalid), .current_input_a(cur_a), .current_input_b(cur_b),
		.calibration_rate_select(csel), .rate_select_high(shi), .rate_select_low(slo),
		.calibration_pulse_out(cal), .low_rate_pulse_a(pa), .low_rate_pulse_b(pb),
		.miswire_alarm(alarm), .reverse_power_flag(rev));
	epf_counter_model far (.mclk(mclk), .cal(cal), .pa(pa), .pb(pb), .rev(rev), .cal_n(cal_n),
		.cal_per(cal_per), .cal_wid(cal_wid), .lr_wid(lr_wid), .alt_err(alt_err), .gap_min(gap_min),
		.fall_d0(fall_d0), .fall_d1(fall_d1), .rev_err(rev_err));

	// Clock, 100 MHz
	always #5 mclk = ~mclk;

	// Hang guard; whole run needs well under this
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic set_currents(input logic [PWR_W-1:0] a, input logic [PWR_W-1:0] b);
		@(negedge mclk);
		cur_a = a;
		cur_b = b;
		@(negedge mclk);
	endtask : set_currents

	// Bounded wait for n more calibration pulses
	task automatic wait_cal(input int n);
		int k;
		k = 0;
		s = cal_n;
		while (cal_n < s + n && k < 5000) begin
			@(negedge mclk);
			k++;
		end
	endtask : wait_cal

	task automatic report_and_stop();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// Main sequence
	initial begin
		{mclk, nrst, ce, failures, n_compared, cyc} = '0;
		{pvalid, csel, shi, slo} = 4'h0;
		power = 24'h000000;
		cur_a = 24'h000640;
		cur_b = 24'h000640;
		repeat (12) @(negedge mclk);
		check({cal, pa, pb, alarm, rev}, 32'h0);
		nrst = 1'b1;
		ce = 1'b1;
		repeat (3) @(negedge mclk);
		// Mismatch boundary: 100/1600 is exactly one sixteenth
		set_currents(24'h000640, 24'h0005dc);
		check(alarm, 32'h0);
		set_currents(24'h000640, 24'h0005db);
		check(alarm, 32'h1);
		set_currents(24'h000640, 24'h000640);
		check(alarm, 32'h0);
		set_currents(24'h0005db, 24'h000640);
		check(alarm, 32'h1);
		set_currents(24'h000640, 24'h000640);
		// Every rate code, calibration select high
		power = 24'h001000;
		pvalid = 1'b1;
		csel = 1'b1;
		for (int c = 0; c < 4; c++) begin
			{shi, slo} = c[1:0];
			wait_cal(3);
			check(cal_per, per_exp[c]);
			check(cal_wid, 32'h14);
		end
		// Select low divides by four less
		csel = 1'b0;
		wait_cal(3);
		check(cal_per, 32'h100);
		check(rev, 32'h0);
		// Clock enable low freezes the pulse train
		@(negedge mclk);
		ce = 1'b0;
		s = cal_n;
		repeat (300) @(negedge mclk);
		check(cal_n, s);
		ce = 1'b1;
		// Negative power still pulses and raises the flag
		csel = 1'b1;
		power = 24'hfff000;
		repeat (600) @(negedge mclk);
		check(rev, 32'h1);
		check(cal_per, 32'h40);
		power = 24'h001000;
		repeat (600) @(negedge mclk);
		check(rev, 32'h0);
		check(rev_err, 32'h0);
		// Heavy load: low-rate lines saturate and defer
		csel = 1'b0;
		power = 24'h040000;
		repeat (1200) @(negedge mclk);
		check(lr_wid, 32'h1e);
		check(alt_err, 32'h0);
		check(fall_d0 == fall_d1 && fall_d1 > 0, 32'h1);
		check(gap_min >= MIN_GAP_CYC, 32'h1);
		report_and_stop();
	end
endmodule : epf_outputs_test
